// file: design/bwsc_area_decode.sv
// wait count and external wait enable decode for one area
`timescale 1ns/10ps
module bwsc_area_decode
   import bwsc_pkg::*;
(
   // settings in, decoded wait out
   bwsc_area_if.dec a
);
   logic [3:0] long_cycles; // long wait in cycles

   // long wait table
   always_comb begin
      unique case (a.long_code)
         3'b000: long_cycles = 4'h3;
         3'b001: long_cycles = 4'h4;
         3'b010: long_cycles = 4'h5;
         3'b011: long_cycles = 4'h6;
         3'b100: long_cycles = 4'h8;
         3'b101: long_cycles = 4'hA;
         3'b110: long_cycles = 4'hC;
         3'b111: long_cycles = 4'hE;
      endcase
   end

   // interpretation depends on the memory kind
   always_comb begin
      a.wait_count = 4'h0;
      a.ext_en = 1'b0;
      unique case (a.kind)
         MK_ORD: begin
            unique case (a.wait_field)
               2'b00: a.wait_count = 4'h0;
               2'b01: a.wait_count = 4'h1;
               2'b10: a.wait_count = 4'h2;
               2'b11: a.wait_count = long_cycles;
            endcase
            a.ext_en = (a.wait_field != 2'b00) && !a.mask;
         end
         MK_DRAM: begin
            // extra column strobe cycles beyond the first; 11 treated as 3 cycles
            a.wait_count = {2'b00, a.wait_field};
            a.ext_en = !a.mask && (a.wait_field != 2'b00);
         end
         MK_SDRAM: begin
            // read latency 1..4, the wait pin never counts here
            a.wait_count = {2'b00, a.wait_field} + 4'h1;
            a.ext_en = 1'b0;
         end
         default: begin
            a.wait_count = 4'h0;
            a.ext_en = 1'b0;
         end
      endcase
   end
endmodule : bwsc_area_decode

// file: design/bwsc_area_if.sv
// per-area settings carried to a wait decoder and its answer back
`timescale 1ns/10ps
interface bwsc_area_if;
   import bwsc_pkg::*;
   logic [1:0] wait_field; // two-bit wait field of the area
   logic [2:0] long_code; // three-bit long wait code
   logic mask; // external wait mask bit
   bwsc_kind_type kind; // memory kind of the area
   logic [3:0] wait_count; // wait cycles to insert
   logic ext_en; // external wait input honoured
   modport cfg (output wait_field, output long_code, output mask, output kind,
      input wait_count, input ext_en);
   modport dec (input wait_field, input long_code, input mask, input kind,
      output wait_count, output ext_en);
endinterface : bwsc_area_if

// file: design/bwsc_cfg.svh
// offsets, field positions, reset values and write masks of the bus wait and size block
`ifndef BWSC_CFG_SVH
`define BWSC_CFG_SVH

// register byte offsets on the bus
`define BWSC_OFS_FIRST 8'h00
`define BWSC_OFS_WIDTH 8'h04
`define BWSC_OFS_LONGW 8'h08
`define BWSC_OFS_IWLOW 8'h0C
`define BWSC_OFS_MASK4 8'h10
`define BWSC_OFS_STAT 8'h14

// reset values
`define BWSC_RST_FIRST 16'h03F0
`define BWSC_RST_WIDTH 16'h00FC
`define BWSC_RST_LONGW 16'h0F00
`define BWSC_RST_IWLOW 16'hAAFF
`define BWSC_RST_MASK4 16'h000B

// writable bits; everything else is reserved
`define BWSC_MSK_FIRST 16'h7BFF
`define BWSC_MSK_WIDTH 16'h03FC
`define BWSC_MSK_LONGW 16'h0FC7
`define BWSC_MSK_IWLOW 16'hFFFF
`define BWSC_MSK_MASK4 16'hDF0F

// field positions
`define BWSC_MEMTYPE_LSB 0
`define BWSC_A4LW_LSB 13
`define BWSC_AHLW_LSB 8
`define BWSC_A1LW_LSB 6
`define BWSC_A0LW_LSB 4
`define BWSC_A4LW2_BIT 11
`define BWSC_SHARED_AREA23_LONG_WAIT_HIGH_BIT 10
`define BWSC_A1LW2_BIT 9
`define BWSC_A0LW2_BIT 8
`define BWSC_DSWW_LSB 6
`define BWSC_BANK_COUNT_SELECT_BIT 2
`define BWSC_EDO_BIT 1
`define BWSC_BWE_BIT 0
`define BWSC_IW_LSB 8
`define BWSC_W_LSB 0
`define BWSC_A4WD_LSB 14
`define BWSC_WM_LSB 8
`define BWSC_IW4_LSB 2
`define BWSC_W4_LSB 0
`define BWSC_A4SZ_LSB 8
`define BWSC_A1SZ_LSB 2

`endif

// file: design/bwsc_pkg.sv
// types shared by the bus wait and size block
package bwsc_pkg;
   // kind of memory behind an area
   typedef enum logic [1:0] {
      MK_ORD = 2'b00,
      MK_SDRAM = 2'b01,
      MK_DRAM = 2'b10
   } bwsc_kind_type;
   // access width of the current cycle
   typedef enum logic [1:0] {
      WD_MEMCTRL = 2'b00,
      WD_8 = 2'b01,
      WD_16 = 2'b10,
      WD_32 = 2'b11
   } bwsc_width_type;
   // access sequencer states
   typedef enum logic [2:0] {
      ST_READY = 3'b000,
      ST_GAP = 3'b001,
      ST_WAIT = 3'b010,
      ST_EXT = 3'b011,
      ST_RELEASE = 3'b100,
      ST_DONE = 3'b101
   } bwsc_state_type;
   // all state of the top module
   typedef struct packed {
      logic [15:0] first_r;
      logic [15:0] width_r;
      logic [15:0] longw_r;
      logic [15:0] iwlow_r;
      logic [15:0] mask4_r;
      logic ack;
      logic [31:0] rdata;
      bwsc_state_type st;
      logic [3:0] cnt;
      logic [3:0] wcnt;
      logic [2:0] area;
      logic wr;
      logic ext_en;
      logic [3:0] rel;
      logic waited;
      bwsc_width_type width;
      bwsc_kind_type kind;
      logic prev_valid;
      logic [2:0] prev_area;
      logic prev_rd;
      logic [1:0] prev_idle;
   } bwsc_regs_type;
endpackage : bwsc_pkg

// file: design/bwsc_top.sv
// bus wait and size configuration with its access sequencer and wishbone slave
//
// Chosen here: the Wishbone register port and the placing of the registers.
`timescale 1ns/10ps
`include "bwsc_cfg.svh"
module bwsc_top
   import bwsc_pkg::*;
#(
   parameter bwsc_width_type AREA0_WIDTH = WD_32 // area 0 width, strapped outside
)(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // external access requests
   input wire logic acc_valid_i,
   input wire logic [2:0] acc_area_i,
   input wire logic acc_write_i,
   output logic acc_ready_o,
   output logic acc_active_o,
   output logic acc_done_o,
   output logic [1:0] acc_width_o,
   // external wait pin, active low
   input wire logic ext_wait_n_i,
   // memory controller side
   input wire logic [2:0] addr_mux_i,
   output logic sdram_two_banks_o,
   output logic dram_edo_mode_o,
   output logic sdram_burst_write_o,
   output logic [1:0] dma_single_waits_o,
   output logic [1:0] area2_kind_o,
   output logic [1:0] area3_kind_o
);
   bwsc_regs_type r; // registered state
   bwsc_regs_type n; // next state

   // per-area carriers
   bwsc_area_if area_if[5](); // one carrier per area
   bwsc_kind_type kind2; // area 2 memory kind
   bwsc_kind_type kind3; // area 3 memory kind
   // gathered settings
   logic [1:0] wf [5]; // wait fields
   logic [2:0] lc [5]; // long codes
   logic [1:0] iw [5]; // idle fields
   // decoder answers
   logic [3:0] dec_cnt [5]; // decoded wait counts
   logic dec_ext [5]; // decoded wait enables
   bwsc_kind_type knd [5]; // kinds per area

   // memory type field classifies areas 2 and 3; reserved codes fall to ordinary
   always_comb begin
      kind2 = MK_ORD;
      kind3 = MK_ORD;
      unique case (r.first_r[`BWSC_MEMTYPE_LSB +: 3])
         3'b001: kind3 = MK_SDRAM;
         3'b010: kind3 = MK_DRAM;
         3'b100: kind2 = MK_SDRAM;
         // both areas synchronous
         3'b101: begin
            kind2 = MK_SDRAM;
            kind3 = MK_SDRAM;
         end
         // ordinary and reserved codes
         default: begin
            kind2 = MK_ORD;
            kind3 = MK_ORD;
         end
      endcase
   end

   // per-area field gathering
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wf[i] = r.iwlow_r[`BWSC_W_LSB + 2 * i +: 2];
         iw[i] = r.iwlow_r[`BWSC_IW_LSB + 2 * i +: 2];
      end
      // area 4 fields sit in the mask register
      wf[4] = r.mask4_r[`BWSC_W4_LSB +: 2];
      iw[4] = r.mask4_r[`BWSC_IW4_LSB +: 2];
      // long code: top bit apart from the low two
      lc[0] = {r.longw_r[`BWSC_A0LW2_BIT], r.first_r[`BWSC_A0LW_LSB +: 2]};
      lc[1] = {r.longw_r[`BWSC_A1LW2_BIT], r.first_r[`BWSC_A1LW_LSB +: 2]};
      // one code serves both areas 2 and 3
      lc[2] = {r.longw_r[`BWSC_SHARED_AREA23_LONG_WAIT_HIGH_BIT], r.first_r[`BWSC_AHLW_LSB +: 2]};
      lc[3] = lc[2];
      lc[4] = {r.longw_r[`BWSC_A4LW2_BIT], r.first_r[`BWSC_A4LW_LSB +: 2]};
      // only areas 2 and 3 vary
      knd[0] = MK_ORD;
      knd[1] = MK_ORD;
      knd[2] = kind2;
      knd[3] = kind3;
      knd[4] = MK_ORD;
   end

   // one decoder per area
   for (genvar g = 0; g < 5; g++) begin : g_area
      assign area_if[g].wait_field = wf[g];
      assign area_if[g].long_code = lc[g];
      assign area_if[g].mask = r.mask4_r[`BWSC_WM_LSB + g];
      assign area_if[g].kind = knd[g];
      assign dec_cnt[g] = area_if[g].wait_count;
      assign dec_ext[g] = area_if[g].ext_en;
      // each decoder sees its own area only
      bwsc_area_decode bwsc_area_decode_inst (
         .a (area_if[g].dec)
      );
   end

   // idle field code to cycles
   function automatic logic [3:0] idle_cycles(input logic [1:0] f);
      logic [3:0] c;
      c = 4'h0;
      // top code is four, not three
      unique case (f)
         2'b00: c = 4'h0;
         2'b01: c = 4'h1;
         2'b10: c = 4'h2;
         2'b11: c = 4'h4;
      endcase
      return c;
   endfunction : idle_cycles

   // area 4 release delay code to cycles; reserved 11 treated as 4
   function automatic logic [3:0] release_cycles(input logic [1:0] f);
      logic [3:0] c;
      c = 4'h1;
      // reserved 11 stretches to the longest
      unique case (f)
         2'b00: c = 4'h1;
         2'b01: c = 4'h2;
         2'b10: c = 4'h4;
         2'b11: c = 4'h4;
      endcase
      return c;
   endfunction : release_cycles

   // width of an area from its two-bit field
   function automatic bwsc_width_type width_of(input logic [2:0] ar, input logic [15:0] wr,
         input bwsc_kind_type k);
      logic [1:0] f;
      bwsc_width_type w;
      f = 2'b00;
      w = WD_32;
      // area 4 reads 00 as 32-bit too
      if (ar == 3'd4) begin
         f = wr[`BWSC_A4SZ_LSB +: 2];
         unique case (f)
            2'b01: w = WD_8;
            2'b10: w = WD_16;
            default: w = WD_32;
         endcase
      end else if (ar == 3'd0) begin
         // area 0 is strapped, not programmed
         w = AREA0_WIDTH;
      end else if (k != MK_ORD) begin
         // dram kinds take their width from the memory controller
         w = WD_MEMCTRL;
      end else begin
         f = wr[`BWSC_A1SZ_LSB + 2 * (32'(ar) - 1) +: 2];
         unique case (f)
            2'b01: w = WD_8;
            2'b10: w = WD_16;
            default: w = WD_32; // 00 must not be programmed
         endcase
      end
      return w;
   endfunction : width_of

   // byte-lane write with reserved bits forced to zero
   function automatic logic [15:0] lane_write(input logic [15:0] old, input logic [31:0] d,
         input logic [3:0] s, input logic [15:0] m);
      logic [15:0] v;
      v = old;
      // only the low half is implemented
      if (s[0]) begin
         v[7:0] = d[7:0];
      end
      if (s[1]) begin
         v[15:8] = d[15:8];
      end
      return v & m;
   endfunction : lane_write

   logic bus_req; // valid wishbone request
   logic [2:0] sel_area; // requested area, clamped to a legal index
   logic need_gap; // idle cycles needed before this access

   // next-state logic: register file and access sequencer
   always_comb begin
      n = r;
      bus_req = cyc_i && stb_i;
      sel_area = (acc_area_i > 3'd4) ? 3'd4 : acc_area_i;
      // a change of area, or a read followed by a write, needs turnaround
      need_gap = r.prev_valid &&
         ((sel_area != r.prev_area) || (r.prev_rd && acc_write_i));

      // ack rises one cycle after the request and drops right after
      n.ack = bus_req && !r.ack;
      if (bus_req && !r.ack) begin
         unique case (adr_i)
            `BWSC_OFS_FIRST: n.rdata = {16'h0000, r.first_r};
            `BWSC_OFS_WIDTH: n.rdata = {16'h0000, r.width_r};
            `BWSC_OFS_LONGW: n.rdata = {16'h0000, r.longw_r};
            `BWSC_OFS_IWLOW: n.rdata = {16'h0000, r.iwlow_r};
            `BWSC_OFS_MASK4: n.rdata = {16'h0000, r.mask4_r};
            // live sequencer view, read only
            `BWSC_OFS_STAT: n.rdata = {16'h0000, 1'b0, r.st, r.area, r.prev_area,
               1'b0, r.cnt, r.waited};
            default: n.rdata = 32'h0000_0000; // unmapped reads zero
         endcase
      end

      // write lands on the edge where ack is seen; sequencer snapshots isolate it
      if (bus_req && r.ack && we_i) begin
         unique case (adr_i)
            `BWSC_OFS_FIRST: n.first_r = lane_write(r.first_r, dat_i, sel_i, `BWSC_MSK_FIRST);
            `BWSC_OFS_WIDTH: n.width_r = lane_write(r.width_r, dat_i, sel_i, `BWSC_MSK_WIDTH);
            `BWSC_OFS_LONGW: n.longw_r = lane_write(r.longw_r, dat_i, sel_i, `BWSC_MSK_LONGW);
            `BWSC_OFS_IWLOW: n.iwlow_r = lane_write(r.iwlow_r, dat_i, sel_i, `BWSC_MSK_IWLOW);
            `BWSC_OFS_MASK4: n.mask4_r = lane_write(r.mask4_r, dat_i, sel_i, `BWSC_MSK_MASK4);
            // status and holes ignore writes
            default: n.rdata = r.rdata; // unmapped or read-only: write dropped
         endcase
      end

      // sequencer
      unique case (r.st)
         ST_READY: begin
            // idle until a request
            if (acc_valid_i) begin
               // settings frozen here for the whole cycle
               n.area = sel_area;
               n.wr = acc_write_i;
               n.ext_en = dec_ext[sel_area];
               n.rel = release_cycles(r.mask4_r[`BWSC_A4WD_LSB +: 2]);
               n.width = width_of(sel_area, r.width_r, knd[sel_area]);
               n.kind = knd[sel_area];
               n.waited = 1'b0;
               n.wcnt = dec_cnt[sel_area];
               // gap length comes from the area of the previous cycle
               n.cnt = need_gap ? idle_cycles(r.prev_idle) : 4'h0;
               n.st = ST_GAP;
            end
         end

         ST_GAP: begin
            // idle cycles run first
            if (r.cnt == 4'h0) begin
               n.cnt = r.wcnt;
               n.st = ST_WAIT;
            end else begin
               n.cnt = r.cnt - 4'h1;
            end
         end

         ST_WAIT: begin
            // programmed waits count down
            if (r.cnt == 4'h0) begin
               n.st = ST_EXT;
            end else begin
               n.cnt = r.cnt - 4'h1;
            end
         end

         ST_EXT: begin
            // wait pin sampled only after the programmed waits
            if (r.ext_en && !ext_wait_n_i) begin
               // held while the pin asks
               n.waited = 1'b1;
            end else if (r.area == 3'd4 && r.waited) begin
               n.cnt = r.rel - 4'h1;
               n.st = ST_RELEASE;
            end else begin
               n.st = ST_DONE;
            end
         end

         ST_RELEASE: begin
            // area 4 strobe release delay
            if (r.cnt == 4'h0) begin
               n.st = ST_DONE;
            end else begin
               n.cnt = r.cnt - 4'h1;
            end
         end

         ST_DONE: begin
            // history for the next gap
            n.prev_valid = 1'b1;
            n.prev_area = r.area;
            n.prev_rd = !r.wr;
            n.prev_idle = iw[r.area];
            n.st = ST_READY;
         end

         default: n.st = ST_READY;
      endcase
   end

   // state register, synchronous reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // history clears, registers reload
         r <= '0;
         r.first_r <= `BWSC_RST_FIRST;
         r.width_r <= `BWSC_RST_WIDTH;
         r.longw_r <= `BWSC_RST_LONGW;
         r.iwlow_r <= `BWSC_RST_IWLOW;
         r.mask4_r <= `BWSC_RST_MASK4;
         r.st <= ST_READY;
         r.width <= WD_32;
         r.kind <= MK_ORD;
      end else begin
         r <= n;
      end
   end

   // outputs
   assign dat_o = r.rdata;
   assign ack_o = r.ack;
   // handshakes decode the state register
   assign acc_ready_o = (r.st == ST_READY);
   assign acc_active_o = (r.st == ST_WAIT) || (r.st == ST_EXT) || (r.st == ST_RELEASE);
   assign acc_done_o = (r.st == ST_DONE);
   assign acc_width_o = r.width;

   // bank count matters only for the 64-Mbit multiplex codes
   assign sdram_two_banks_o = (addr_mux_i[2:1] == 2'b10) &&
      r.longw_r[`BWSC_BANK_COUNT_SELECT_BIT];
   assign dram_edo_mode_o = (kind3 == MK_DRAM) && r.longw_r[`BWSC_EDO_BIT];
   assign sdram_burst_write_o = ((kind2 == MK_SDRAM) || (kind3 == MK_SDRAM)) &&
      r.longw_r[`BWSC_BWE_BIT];

   // reserved code 11 clamps to two waits
   assign dma_single_waits_o = (r.longw_r[`BWSC_DSWW_LSB +: 2] == 2'b11) ? 2'b10 :
      r.longw_r[`BWSC_DSWW_LSB +: 2];
   // memory kinds for the controller
   assign area2_kind_o = kind2;
   assign area3_kind_o = kind3;
endmodule : bwsc_top

// file: verif/bus_wait_size_config_bench.sv
// self-checking bench of the bus wait and size block
`timescale 1ns/10ps
`define BWSC_CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
   $display("Error %s expected %0h seen %0h", nm, e, g); end end
module bus_wait_size_config_bench;
   import bwsc_pkg::*;
   typedef struct packed {
      logic [7:0] adr;
      logic [15:0] dat;
      logic [2:0] area;
      logic [3:0] dl;
      logic [1:0] wd;
   } bwsc_row_type;
   typedef struct packed {
      logic [15:0] f;
      logic [15:0] l;
      logic [2:0] mx;
      logic [3:0] st;
      logic [3:0] dl;
      logic [8:0] ex;
   } bwsc_opt_type;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic acc_valid_i = 1'b0, acc_write_i = 1'b0, ack_o, acc_ready_o, acc_active_o;
   logic acc_done_o, sdram_two_banks_o, dram_edo_mode_o, sdram_burst_write_o, ext_wait_n_i;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h3, stall = 4'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd;
   logic [2:0] acc_area_i = 3'h0, addr_mux_i = 3'h0;
   logic [1:0] acc_width_o, dma_single_waits_o, area2_kind_o, area3_kind_o;
   logic [8:0] mc;
   int n_mismatch = 0, compares = 0, lat, base, r0;
   // register reset values
   logic [31:0] rst_tab[5] = '{32'h03F0, 32'h00FC, 32'h0F00, 32'hAAFF, 32'h000B};
   // register write, area, extra waits over base, width
   bwsc_row_type rows[18] = '{'{8'h08, 16'h0000, 3'd1, 4'd6, 2'b11},
      '{8'h00, 16'h0000, 3'd1, 4'd3, 2'b11}, '{8'h00, 16'h0040, 3'd1, 4'd4, 2'b11},
      '{8'h00, 16'h0080, 3'd1, 4'd5, 2'b11}, '{8'h08, 16'h0200, 3'd1, 4'd12, 2'b11},
      '{8'h00, 16'h0040, 3'd1, 4'd10, 2'b11}, '{8'h00, 16'h0000, 3'd1, 4'd8, 2'b11},
      '{8'h00, 16'h00C0, 3'd1, 4'd14, 2'b11}, '{8'h00, 16'h0300, 3'd2, 4'd6, 2'b11},
      '{8'h08, 16'h0400, 3'd3, 4'd14, 2'b11}, '{8'h08, 16'h0400, 3'd2, 4'd14, 2'b11},
      '{8'h0C, 16'h00FD, 3'd0, 4'd1, 2'b11}, '{8'h0C, 16'h00FE, 3'd0, 4'd2, 2'b11},
      '{8'h00, 16'h2000, 3'd4, 4'd4, 2'b11}, '{8'h04, 16'h01FC, 3'd4, 4'd4, 2'b01},
      '{8'h04, 16'h02FC, 3'd4, 4'd4, 2'b10}, '{8'h04, 16'h0354, 3'd1, 4'd3, 2'b01},
      '{8'h04, 16'h03A8, 3'd3, 4'd8, 2'b10}};
   // memory type and options, area 3 waits, expected controller outputs
   bwsc_opt_type opts[6] = '{'{16'h0002, 16'h0042, 3'b000, 4'd0, 4'd2, 9'b0_1_0_01_00_10},
      '{16'h0002, 16'h0080, 3'b100, 4'd0, 4'd2, 9'b0_0_0_10_00_10},
      '{16'h0005, 16'h0005, 3'b100, 4'd6, 4'd3, 9'b1_0_1_00_01_01},
      '{16'h0005, 16'h0005, 3'b001, 4'd6, 4'd3, 9'b0_0_1_00_01_01},
      '{16'h0004, 16'h0002, 3'b101, 4'd0, 4'd2, 9'b0_0_0_00_01_00},
      '{16'h0001, 16'h0006, 3'b101, 4'd6, 4'd3, 9'b1_0_0_00_00_01}};
   int rel_dl[3] = '{0, 1, 3}; // release codes 00, 01, 10
   // area, write flag, idle cycles expected
   logic [7:0] idl[5] = '{8'h20, 8'h41, 8'h24, 8'h31, 8'h20};
   assign mc = {sdram_two_banks_o, dram_edo_mode_o, sdram_burst_write_o,
      dma_single_waits_o, area2_kind_o, area3_kind_o};
   always #20 clk_i = ~clk_i;
   bwsc_top bwsc_top_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
      .dat_o, .ack_o, .acc_valid_i, .acc_area_i, .acc_write_i, .acc_ready_o, .acc_active_o,
      .acc_done_o, .acc_width_o, .ext_wait_n_i, .addr_mux_i, .sdram_two_banks_o,
      .dram_edo_mode_o, .sdram_burst_write_o, .dma_single_waits_o, .area2_kind_o,
      .area3_kind_o);
   bwsc_mem_model bwsc_mem_model_inst (.clk_i, .rst_i, .active_i(acc_active_o),
      .stall_i(stall), .ext_wait_n_o(ext_wait_n_i));
   // one classic wishbone cycle, bounded wait for ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {16'h0000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (n >= 50) n_mismatch++;
   endtask : wb
   // one access; lat counts edges from take to end of done
   task automatic acc(input logic [2:0] a, input logic w);
      int n;
      n = 0;
      @(posedge clk_i);
      acc_valid_i <= 1'b1;
      acc_area_i <= a;
      acc_write_i <= w;
      do begin
         @(posedge clk_i);
         n++;
      end while (acc_ready_o !== 1'b1 && n < 50);
      acc_valid_i <= 1'b0;
      lat = 0;
      do begin
         @(posedge clk_i);
         lat++;
      end while (acc_done_o !== 1'b1 && lat < 100);
      if (lat >= 100 || n >= 50) n_mismatch++;
   endtask : acc
   task automatic final_report();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report
   // watchdog well past the expected few hundred cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      n_mismatch++;
      final_report();
   end
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         wb(1'b0, 8'(4 * i), 16'h0000);
         `BWSC_CHK("reset value", rst_tab[i], rd)
      end
      wb(1'b1, 8'h04, 16'hFFFF);
      wb(1'b0, 8'h04, 16'h0000);
      `BWSC_CHK("reserved width bits", 32'h03FC, rd)
      wb(1'b1, 8'h10, 16'hFFFF);
      wb(1'b0, 8'h10, 16'h0000);
      `BWSC_CHK("reserved mask bits", 32'hDF0F, rd)
      wb(1'b0, 8'h20, 16'h0000);
      `BWSC_CHK("unmapped read", 32'h0, rd)
      $display("register test done");
      // no idle cycles, area 0 without waits gives the base latency
      wb(1'b1, 8'h04, 16'h00FC);
      wb(1'b1, 8'h10, 16'h0003);
      wb(1'b1, 8'h0C, 16'h00FC);
      acc(3'd0, 1'b0);
      base = lat;
      foreach (rows[i]) begin
         wb(1'b1, rows[i].adr, rows[i].dat);
         acc(rows[i].area, 1'b0);
         `BWSC_CHK("wait cycles", base + rows[i].dl, lat)
         `BWSC_CHK("access width", rows[i].wd, acc_width_o)
      end
      $display("wait and width test done");
      wb(1'b1, 8'h0C, 16'h00BE);
      foreach (opts[i]) begin
         wb(1'b1, 8'h00, opts[i].f);
         wb(1'b1, 8'h08, opts[i].l);
         addr_mux_i <= opts[i].mx;
         stall <= opts[i].st;
         acc(3'd3, 1'b0);
         `BWSC_CHK("area 3 waits", base + opts[i].dl, lat)
         `BWSC_CHK("memory options", opts[i].ex, mc)
      end
      $display("memory option test done");
      stall <= 4'd6;
      acc(3'd0, 1'b0);
      `BWSC_CHK("wait held", base + 5, lat)
      wb(1'b1, 8'h10, 16'h0103);
      acc(3'd0, 1'b0);
      `BWSC_CHK("wait masked", base + 2, lat)
      wb(1'b1, 8'h0C, 16'h00BC);
      wb(1'b1, 8'h10, 16'h0003);
      acc(3'd0, 1'b0);
      `BWSC_CHK("wait disabled", base, lat)
      // area 4 held by the pin, release delay grows the access
      for (int i = 0; i < 3; i++) begin
         wb(1'b1, 8'h10, {2'(i), 14'h0003});
         acc(3'd4, 1'b0);
         if (i == 0) r0 = lat;
         else `BWSC_CHK("release delay", r0 + rel_dl[i], lat)
      end
      $display("external wait test done");
      stall <= 4'd0;
      wb(1'b1, 8'h0C, 16'h34C3);
      foreach (idl[i]) begin
         acc(idl[i][7:5], idl[i][4]);
         `BWSC_CHK("idle cycles", base + idl[i][3:0], lat)
      end
      $display("idle test done");
      final_report();
   end
endmodule : bus_wait_size_config_bench

// file: verif/bwsc_assertions.sv
// checker of the bus wait and size top ports
`timescale 1ns/10ps
module bwsc_checker
   import bwsc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic [31:0] dat_o,
   // access sequencer
   input wire logic acc_valid_i,
   input wire logic acc_ready_o,
   input wire logic acc_done_o,
   input wire logic [1:0] acc_width_o,
   // memory controller side
   input wire logic [2:0] addr_mux_i,
   input wire logic sdram_two_banks_o,
   input wire logic dram_edo_mode_o,
   input wire logic sdram_burst_write_o,
   input wire logic [1:0] dma_single_waits_o,
   input wire logic [1:0] area2_kind_o,
   input wire logic [1:0] area3_kind_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire take = acc_valid_i && acc_ready_o; // request accepted
   property p_ack;
      cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not a single pulse");
   property p_hi_zero;
      ack_o |-> dat_o[31:16] == 16'h0000;
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("upper read data set");
   property p_dsww;
      dma_single_waits_o != 2'b11;
   endproperty
   a_dsww: assert property (p_dsww) else $error("dma waits code 11");
   property p_banks;
      sdram_two_banks_o |-> addr_mux_i[2:1] == 2'b10;
   endproperty
   a_banks: assert property (p_banks) else $error("two banks without 64M");
   property p_edo;
      dram_edo_mode_o |-> area3_kind_o == MK_DRAM;
   endproperty
   a_edo: assert property (p_edo) else $error("edo without dram");
   property p_burst;
      sdram_burst_write_o |-> area2_kind_o == MK_SDRAM || area3_kind_o == MK_SDRAM;
   endproperty
   a_burst: assert property (p_burst) else $error("burst without sdram");
   property p_kind2;
      area2_kind_o != MK_DRAM;
   endproperty
   a_kind2: assert property (p_kind2) else $error("area 2 as dram");
   property p_min;
      take |=> !acc_done_o [*2];
   endproperty
   a_min: assert property (p_min) else $error("access ended too soon");
   property p_max;
      take |-> ##[3:80] acc_done_o;
   endproperty
   a_max: assert property (p_max) else $error("access never ended");
   property p_width;
      !take |=> $stable(acc_width_o);
   endproperty
   a_width: assert property (p_width) else $error("width moved between takes");
   property p_done;
      acc_done_o |=> acc_ready_o && !acc_done_o;
   endproperty
   a_done: assert property (p_done) else $error("no ready after done");
   // main scenarios
   c_take: cover property (take);
   c_held: cover property (take ##[20:80] acc_done_o);
   c_banks: cover property (sdram_two_banks_o);
endmodule : bwsc_checker
bind bwsc_top bwsc_checker bwsc_checker_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o,
   .dat_o, .acc_valid_i, .acc_ready_o, .acc_done_o, .acc_width_o, .addr_mux_i,
   .sdram_two_banks_o, .dram_edo_mode_o, .sdram_burst_write_o, .dma_single_waits_o,
   .area2_kind_o, .area3_kind_o);

// file: verif/bwsc_mem_model.sv
// wait pin model of the memories and devices on the areas
`timescale 1ns/10ps
module bwsc_mem_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // access in progress and stall length
   input wire logic active_i,
   input wire logic [3:0] stall_i,
   // wait pin, active low
   output logic ext_wait_n_o
);
   logic [3:0] cnt_r; // cycles into the access
   logic [3:0] cnt_nxt;
   // count from each access start, saturating
   always_comb begin
      cnt_nxt = cnt_r;
      if (!active_i) begin
         cnt_nxt = 4'h0;
      end else if (cnt_r != 4'hF) begin
         cnt_nxt = cnt_r + 4'h1;
      end
   end
   always_ff @(posedge clk_i) begin
      cnt_r <= rst_i ? 4'h0 : cnt_nxt;
   end
   // pulled up outside accesses, so idle never reads as a wait
   assign ext_wait_n_o = !(active_i && cnt_r < stall_i);
endmodule : bwsc_mem_model
